// [trigger_strobe_timing.v]
// Overview of operation
// R1: host selects trigger mode 0 normal, 1 external, 2 internal strobe-synchronised.
// R2: normal mode starts integration as soon as a spectrum request arrives.
// R3: external mode without delay starts integration 200 ns +/- 100 ns after edge.
// R4: nonzero trigger delay runs a timer, 5 us to 335.5 ms, then integrates.
// R5: trigger delay counts in 1 us steps.
// R6: internal mode triggers at next continuous strobe edge, then delay or integrate.
// R7: internal mode integration starts 4.24 us before continuous strobe rises.
// R8: one single strobe pulse with programmable delay and width.
// R9: single strobe delay spans 5 us to 335.5 ms.
// R10: zero trigger delay times single strobe from integration start.
// R11: nonzero trigger delay starts strobe and delay timers together.
// R12: host keeps strobe edges and delayed start at least 3 us apart.
// R13: coincident timing events may update outputs one after another.
// R14: continuous strobe period 50 us to 5 s in 1 us steps.
// R15: host uses internal mode for several strobes per integration.
// R16: one acquisition cycle lasts no less than 13.3 ms.
// R17: four general purpose pins with software direction and level.
// R18: query on endpoint 1 or 2 answered on matching endpoint, even mid-acquisition.
// R19: acquisition rate up to about 75 Hz.
// R20: external trigger sensed on rising edge.
// R21: lamp drive rises once lamp enabled and a spectrum request follows.
// R22: timers count 1 us from core clock; reset clears them, outputs low.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "trigger_strobe_defines.vh"

module trigger_strobe_timing (
  // clock and reset
  input  wire        core_clk,
  input  wire        nrst,
  // register port
  input  wire [7:0]  addr,
  input  wire [31:0] wrData,
  input  wire        wrStb,
  input  wire        rdStb,
  output reg  [31:0] rdData,
  // acquisition pins
  input  wire        external_trigger_input,
  output reg         integrating,
  output reg         singleStrobe,
  output reg         contStrobe,
  output reg         lampDrive,
  // general purpose pins
  input  wire [3:0]  gpioIn,
  output reg  [3:0]  gpioOut,
  output reg  [3:0]  gpioOe,
  // endpoint queries
  input  wire [1:0]  epOutQuery,
  output reg  [1:0]  epInReply
);

  localparam       TW       = 24;
  localparam [31:0] CLK_CYC = `CLK_MHZ;
  localparam [7:0] CYC_US   = CLK_CYC[7:0];
  localparam [31:0] LAT_CYC = `EXT_LAT_CYC - `SYNC_STAGES;
  localparam [31:0] LEAD    = `CS_LEAD_CYC;
  localparam [31:0] LEAD_HI = `CS_LEAD_CYC + `CS_HIGH_CYC;

  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_ARM   = 5'h02;
  localparam [4:0] ST_DELAY = 5'h04;
  localparam [4:0] ST_INTEG = 5'h08;
  localparam [4:0] ST_CYCLE = 5'h10;

  // ----------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------
  reg rstQ1;
  reg rstN;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstQ1 <= 1'b0;
      rstN  <= 1'b0;
    end else begin
      rstQ1 <= 1'b1;
      rstN  <= rstQ1;
    end
  end

  reg       extQ1;
  reg       extQ2;
  reg       extPrev;
  reg [3:0] gpioQ1;
  reg [3:0] gpioQ2;

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      extQ1   <= 1'b0;
      extQ2   <= 1'b0;
      extPrev <= 1'b0;
    end else begin
      extQ1   <= external_trigger_input;
      extQ2   <= extQ1;
      extPrev <= extQ2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gpioSync
      always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
          gpioQ1[g] <= 1'b0;
          gpioQ2[g] <= 1'b0;
        end else begin
          gpioQ1[g] <= gpioIn[g];
          gpioQ2[g] <= gpioQ1[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [4:0]    ctrl;
  reg  [TW-1:0] trigDelay;
  reg  [TW-1:0] ssDelay;
  reg  [TW-1:0] ssWidth;
  reg  [TW-1:0] csPeriod;
  reg  [TW-1:0] integTime;
  reg  [3:0]    gpioDir;
  reg  [3:0]    gpioLevel;
  reg           acqDone;
  reg  [4:0]    state;
  reg  [31:0]   rdMux;

  wire [TW-1:0] wv     = wrData[TW-1:0];
  wire          wrOn   = wrStb & ~rdStb;
  wire          perWr  = wrOn & (addr == `ADDR_CS_PERIOD);
  wire          reqPulse = wrOn & (addr == `ADDR_CMD) & wrData[`CMD_REQUEST];
  wire [1:0]    mode   = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire          setDone;

  function [TW-1:0] clampv;
    input [TW-1:0] v;
    input [TW-1:0] lo;
    input [TW-1:0] hi;
    begin
      clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ctrl      <= `CTRL_RST;
      trigDelay <= `TRIG_DELAY_RST;
      ssDelay   <= `SS_DELAY_RST;
      ssWidth   <= `SS_WIDTH_RST;
      csPeriod  <= `CS_PERIOD_RST;
      integTime <= `INTEG_TIME_RST;
      gpioDir   <= `GPIO_RST;
      gpioLevel <= `GPIO_RST;
    end else if (wrOn) begin
      case (addr)
        `ADDR_CTRL: begin
          // mode 3 does not exist, so a write carrying it keeps the old mode
          if (wrData[`CTRL_MODE_HI:`CTRL_MODE_LO] != 2'h3) begin
            ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] <= wrData[`CTRL_MODE_HI:`CTRL_MODE_LO]; // R1
          end
          ctrl[`CTRL_SS_EN:`CTRL_LAMP] <= wrData[`CTRL_SS_EN:`CTRL_LAMP];
        end
        `ADDR_TRIG_DELAY: begin
          // zero means no delay; anything else is held inside the legal span
          trigDelay <= (wv == {TW{1'b0}}) ? wv : clampv(wv, `MIN_DELAY_US, `MAX_DELAY_US); // R4 R5
        end
        `ADDR_SS_DELAY:   ssDelay   <= clampv(wv, `MIN_DELAY_US, `MAX_DELAY_US); // R9
        `ADDR_SS_WIDTH:   ssWidth   <= clampv(wv, {TW{1'b0}}, `MAX_DELAY_US); // R8
        `ADDR_CS_PERIOD:  csPeriod  <= clampv(wv, `CS_MIN_US, `CS_MAX_US); // R14
        `ADDR_INTEG_TIME: integTime <= clampv(wv, `INTEG_MIN_US, `INTEG_MAX_US);
        `ADDR_GPIO_DIR:   gpioDir   <= wrData[3:0]; // R17
        `ADDR_GPIO_OUT:   gpioLevel <= wrData[3:0]; // R17
        default: ;
      endcase
    end
  end

  // sticky done flag; a completion landing on the clearing write still sets it
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      acqDone <= 1'b0;
    end else if (setDone) begin
      acqDone <= 1'b1;
    end else if (wrOn && addr == `ADDR_STATUS && wrData[`STATUS_DONE]) begin
      acqDone <= 1'b0;
    end
  end

  always @* begin
    case (addr)
      `ADDR_CTRL:       rdMux = {27'h0000000, ctrl};
      `ADDR_STATUS:     rdMux = {21'h000000, state, lampDrive, contStrobe, singleStrobe,
                                 integrating, (state != ST_IDLE), acqDone};
      `ADDR_TRIG_DELAY: rdMux = {8'h00, trigDelay};
      `ADDR_SS_DELAY:   rdMux = {8'h00, ssDelay};
      `ADDR_SS_WIDTH:   rdMux = {8'h00, ssWidth};
      `ADDR_CS_PERIOD:  rdMux = {8'h00, csPeriod};
      `ADDR_INTEG_TIME: rdMux = {8'h00, integTime};
      `ADDR_GPIO_DIR:   rdMux = {28'h0000000, gpioDir};
      `ADDR_GPIO_OUT:   rdMux = {28'h0000000, gpioLevel};
      `ADDR_GPIO_IN:    rdMux = {28'h0000000, gpioQ2};
      default:          rdMux = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // timers
  // ----------------------------------------
  wire trigDone;
  wire ssDlyDone;
  wire ssWidDone;
  wire csDone;
  wire integDone;
  wire cycBusy;
  wire trigEv;
  wire integStart;
  reg  csRun;

  wire noDelay  = (trigDelay == {TW{1'b0}});
  wire ssLoad   = ctrl[`CTRL_SS_EN] & (noDelay ? integStart : trigEv); // R10 R11
  wire csLoad   = ctrl[`CTRL_CS_EN] & (~csRun | csDone | perWr); // R14
  wire csEvent  = csRun & csDone;

  // every timer counts whole microseconds from the core clock
  us_timer #(.TW(TW), .CYC_US(CYC_US)) trigTimer (
    .clk(core_clk), .rstN(rstN), .load(trigEv & ~noDelay), .value(trigDelay),
    .busy(), .done(trigDone)); // R22 R4
  us_timer #(.TW(TW), .CYC_US(CYC_US)) ssDlyTimer (
    .clk(core_clk), .rstN(rstN), .load(ssLoad), .value(ssDelay),
    .busy(), .done(ssDlyDone)); // R8
  us_timer #(.TW(TW), .CYC_US(CYC_US)) ssWidTimer (
    .clk(core_clk), .rstN(rstN), .load(ssDlyDone), .value(ssWidth),
    .busy(), .done(ssWidDone)); // R8
  us_timer #(.TW(TW), .CYC_US(CYC_US)) csTimer (
    .clk(core_clk), .rstN(rstN), .load(csLoad), .value(csPeriod),
    .busy(), .done(csDone)); // R14
  us_timer #(.TW(TW), .CYC_US(CYC_US)) integTimer (
    .clk(core_clk), .rstN(rstN), .load(integStart), .value(integTime),
    .busy(), .done(integDone));
  us_timer #(.TW(TW), .CYC_US(CYC_US)) cycTimer (
    .clk(core_clk), .rstN(rstN), .load(integStart), .value(`CYCLE_MIN_US),
    .busy(cycBusy), .done()); // R16 R19

  // ----------------------------------------
  // external trigger latency and continuous strobe
  // ----------------------------------------
  reg  [7:0] latCnt;
  reg        latRun;
  reg        extFire;
  reg  [9:0] leadCnt;
  reg        leadRun;

  wire extEdge = extQ2 & ~extPrev; // R20

  // fixed pad so the no-delay response lands near the documented latency
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      latCnt  <= 8'h00;
      latRun  <= 1'b0;
      extFire <= 1'b0;
    end else begin
      extFire <= 1'b0;
      // an edge seen before the request is armed must not start the next acquisition
      if (extEdge && !latRun && state == ST_ARM && mode == `MODE_EXT) begin
        latRun <= 1'b1;
        latCnt <= 8'h01;
      end else if (latRun) begin
        latCnt <= latCnt + 8'h01;
        if (latCnt >= LAT_CYC[7:0]) begin
          latRun  <= 1'b0;
          extFire <= 1'b1; // R3
        end
      end
    end
  end

  // the period event is the trigger point; the pin rises a fixed lead later
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      csRun      <= 1'b0;
      leadCnt    <= 10'h000;
      leadRun    <= 1'b0;
      contStrobe <= 1'b0;
    end else begin
      csRun <= ctrl[`CTRL_CS_EN];
      if (!ctrl[`CTRL_CS_EN]) begin
        leadRun    <= 1'b0;
        contStrobe <= 1'b0;
      end else if (csEvent) begin
        leadRun <= 1'b1;
        leadCnt <= 10'h001;
      end else if (leadRun) begin
        leadCnt <= leadCnt + 10'h001;
        if (leadCnt == LEAD[9:0]) begin
          contStrobe <= 1'b1; // R7
        end
        if (leadCnt == LEAD_HI[9:0]) begin
          contStrobe <= 1'b0;
          leadRun    <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // acquisition sequencer
  // ----------------------------------------
  assign trigEv = (state == ST_ARM) &
                  ((mode == `MODE_NORMAL) | // R2
                   ((mode == `MODE_EXT) & extFire) | // R3
                   ((mode == `MODE_INT) & csEvent)); // R6 R7
  assign integStart = (trigEv & noDelay) | ((state == ST_DELAY) & trigDone); // R4 R6
  assign setDone    = (state == ST_CYCLE) & ~cycBusy;

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state       <= ST_IDLE;
      integrating <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (reqPulse) begin
            state <= ST_ARM;
          end
        end
        ST_ARM: begin
          if (integStart) begin
            state       <= ST_INTEG;
            integrating <= 1'b1;
          end else if (trigEv) begin
            state <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (integStart) begin
            state       <= ST_INTEG;
            integrating <= 1'b1;
          end
        end
        ST_INTEG: begin
          if (integDone) begin
            state       <= ST_CYCLE;
            integrating <= 1'b0;
          end
        end
        ST_CYCLE: begin
          // no new request is armed until the minimum cycle has run out
          if (!cycBusy) begin
            state <= ST_IDLE; // R16 R19
          end
        end
        default: begin
          state       <= ST_IDLE;
          integrating <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // output pins and replies
  // ----------------------------------------
  // each single strobe edge is applied the cycle after its own timer; a rise wins over a coincident fall
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      singleStrobe <= 1'b0;
      lampDrive    <= 1'b0;
      gpioOut      <= `GPIO_RST;
      gpioOe       <= `GPIO_RST;
      epInReply    <= 2'h0;
      rdData       <= 32'h00000000;
    end else begin
      if (ssDlyDone && ssWidth != {TW{1'b0}}) begin
        singleStrobe <= 1'b1; // R8 R13
      end else if (ssWidDone) begin
        singleStrobe <= 1'b0; // R8 R13
      end
      if (!ctrl[`CTRL_LAMP]) begin
        lampDrive <= 1'b0;
      end else if (reqPulse) begin
        lampDrive <= 1'b1; // R21
      end
      gpioOut   <= gpioLevel; // R17
      gpioOe    <= gpioDir; // R17
      epInReply <= epOutQuery; // R18
      rdData    <= rdStb ? rdMux : 32'h00000000;
    end
  end

endmodule // trigger_strobe_timing

// [trigger_strobe_defines.vh]
`ifndef TRIGGER_STROBE_DEFINES_VH
`define TRIGGER_STROBE_DEFINES_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ADDR_CTRL       8'h00
`define ADDR_CMD        8'h04
`define ADDR_STATUS     8'h08
`define ADDR_TRIG_DELAY 8'h0c
`define ADDR_SS_DELAY   8'h10
`define ADDR_SS_WIDTH   8'h14
`define ADDR_CS_PERIOD  8'h18
`define ADDR_INTEG_TIME 8'h1c
`define ADDR_GPIO_DIR   8'h20
`define ADDR_GPIO_OUT   8'h24
`define ADDR_GPIO_IN    8'h28

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_MODE_HI    1
`define CTRL_MODE_LO    0
`define CTRL_LAMP       2
`define CTRL_CS_EN      3
`define CTRL_SS_EN      4
`define CMD_REQUEST     0
`define STATUS_DONE     0

// ----------------------------------------
// trigger mode codes
// ----------------------------------------
`define MODE_NORMAL     2'h0
`define MODE_EXT        2'h1
`define MODE_INT        2'h2

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTRL_RST        5'h00
`define TRIG_DELAY_RST  24'h000000
`define SS_DELAY_RST    24'h000005
`define SS_WIDTH_RST    24'h00000a
`define CS_PERIOD_RST   24'h0003e8
`define INTEG_TIME_RST  24'h00000a
`define GPIO_RST        4'h0

// ----------------------------------------
// timing, in microseconds unless named otherwise
// ----------------------------------------
`define CLK_MHZ         32'h00000064
`define MIN_DELAY_US    24'h000005
`define MAX_DELAY_US    24'h051e8c
`define CS_MIN_US       24'h000032
`define CS_MAX_US       24'h4c4b40
`define INTEG_MIN_US    24'h00000a
`define INTEG_MAX_US    24'h989680
`define CYCLE_MIN_US    24'h0033f4
`define EXT_LAT_NS      32'h000000c8
`define EXT_LAT_CYC     ((`EXT_LAT_NS * `CLK_MHZ) / 32'h000003e8)
`define CS_LEAD_NS      32'h00001090
`define CS_LEAD_CYC     ((`CS_LEAD_NS * `CLK_MHZ) / 32'h000003e8)
`define CS_HIGH_US      32'h00000001
`define CS_HIGH_CYC     (`CS_HIGH_US * `CLK_MHZ)
`define SYNC_STAGES     32'h00000004

`endif

// [us_timer.v]
`timescale 1ns/10ps

module us_timer #(
  parameter       TW     = 24,
  parameter [7:0] CYC_US = 8'h64
) (
  // clock and reset
  input  wire          clk,
  input  wire          rstN,
  // control
  input  wire          load,
  input  wire [TW-1:0] value,
  // state
  output reg           busy,
  output reg           done
);

  reg [7:0]    pre;
  reg [TW-1:0] cnt;

  // ----------------------------------------
  // microsecond countdown
  // ----------------------------------------
  // prescaler restarts on load so every delay is cycle exact, not tick jittered
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pre  <= 8'h00;
      cnt  <= {TW{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt  <= value;
        pre  <= CYC_US - 8'h01;
        busy <= (value != {TW{1'b0}});
      end else if (busy) begin
        if (pre == 8'h00) begin
          pre <= CYC_US - 8'h01;
          cnt <= cnt - {{(TW-1){1'b0}}, 1'b1};
          if (cnt == {{(TW-1){1'b0}}, 1'b1}) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end else begin
          pre <= pre - 8'h01;
        end
      end
    end
  end

endmodule // us_timer

// [trigger_strobe_timing_monitor.sv]
`timescale 1ns/10ps
`include "trigger_strobe_defines.vh"

module trigger_strobe_timing_monitor (
  // clock and reset
  input wire        core_clk,
  input wire        nrst,
  // register port
  input wire [7:0]  addr,
  input wire [31:0] wrData,
  input wire        wrStb,
  input wire        rdStb,
  input wire [31:0] rdData,
  // acquisition pins
  input wire        external_trigger_input,
  input wire        integrating,
  input wire        singleStrobe,
  input wire        contStrobe,
  input wire        lampDrive,
  // general purpose pins
  input wire [3:0]  gpioIn,
  input wire [3:0]  gpioOut,
  input wire [3:0]  gpioOe,
  // endpoint queries
  input wire [1:0]  epOutQuery,
  input wire [1:0]  epInReply
);
  // ----------------
  // helper counters
  // ----------------
  logic [6:0]  csHigh;
  logic [12:0] csLow;
  logic [10:0] integLen;
  logic [20:0] sinceStart;
  logic [1:0]  reqWin;
  // saturating, so a missing edge cannot wrap round into a pass
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      csHigh     <= 7'h00;
      csLow      <= 13'h1fff;
      integLen   <= 11'h000;
      sinceStart <= 21'h1fffff;
      reqWin     <= 2'h0;
    end else begin
      csHigh     <= contStrobe ? csHigh + {6'h00, ~&csHigh} : 7'h00;
      csLow      <= contStrobe ? 13'h0000 : csLow + {12'h000, ~&csLow};
      integLen   <= integrating ? integLen + {10'h000, ~&integLen} : 11'h000;
      sinceStart <= $rose(integrating) ? 21'h000000 : sinceStart + {20'h00000, ~&sinceStart};
      reqWin     <= (wrStb && !rdStb && addr == `ADDR_CMD && wrData[0]) ? 2'h3 : reqWin - {1'b0, |reqWin};
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  reply_match_a: assert property (epOutQuery != 2'h0 |=> epInReply == $past(epOutQuery))
    else $error("endpoint reply does not match query");
  reset_quiet_a: assert property ($rose(nrst) |-> {integrating, singleStrobe, contStrobe, lampDrive, gpioOe} == 8'h00)
    else $error("outputs not quiet after reset");
  cs_width_a: assert property ($fell(contStrobe) |-> csHigh == 7'd100)
    else $error("continuous strobe pulse not 1 us wide");
  cs_period_a: assert property ($rose(contStrobe) |-> csLow >= 13'd4900)
    else $error("continuous strobe period below 50 us");
  integ_min_a: assert property ($fell(integrating) |-> integLen >= 11'd1000)
    else $error("integration shorter than 10 us");
  cycle_gap_a: assert property ($rose(integrating) |-> sinceStart >= 21'd1330000)
    else $error("acquisitions closer than 13.3 ms");
  lamp_req_a: assert property ($rose(lampDrive) |-> reqWin != 2'h0)
    else $error("lamp drive rose without a request");
  gpio_out_a: assert property (wrStb && !rdStb && addr == `ADDR_GPIO_OUT |=>
    ##1 gpioOut == $past(wrData[3:0], 2))
    else $error("pin level not taken from write");
  gpio_dir_a: assert property (wrStb && !rdStb && addr == `ADDR_GPIO_DIR |=>
    ##1 gpioOe == $past(wrData[3:0], 2))
    else $error("pin direction not taken from write");
  integ_start_c: cover property ($rose(integrating));
  single_pulse_c: cover property ($fell(singleStrobe));
  cs_in_integ_c: cover property ($rose(contStrobe) && integrating);
endmodule // trigger_strobe_timing_monitor

bind trigger_strobe_timing trigger_strobe_timing_monitor mon (
  .core_clk(core_clk), .nrst(nrst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
  .rdData(rdData), .external_trigger_input(external_trigger_input), .integrating(integrating),
  .singleStrobe(singleStrobe), .contStrobe(contStrobe), .lampDrive(lampDrive), .gpioIn(gpioIn),
  .gpioOut(gpioOut), .gpioOe(gpioOe), .epOutQuery(epOutQuery), .epInReply(epInReply)
);

// [strobe_lamp_partner.sv]
`timescale 1ns/10ps

module strobe_lamp_partner (
  // clock
  input  wire        core_clk,
  // trigger source
  input  wire        trigCmd,
  output logic       external_trigger_input,
  // strobed lamp
  input  wire        integrating,
  input  wire        contStrobe,
  output logic [7:0] csCount,
  // pads
  input  wire [3:0]  gpioOut,
  input  wire [3:0]  gpioOe,
  input  wire [3:0]  gpioExt,
  output logic [3:0] gpioIn
);
  logic prevCs;
  logic prevInt;
  initial begin
    external_trigger_input = 1'b0;
    csCount = 8'h00;
  end
  // edge lands between clock edges, so the pin is truly asynchronous
  always @(trigCmd) external_trigger_input <= #3 trigCmd;
  // lamp counts flashes within one integration
  always @(posedge core_clk) begin
    prevCs <= contStrobe;
    prevInt <= integrating;
    if (integrating && !prevInt)
      csCount <= 8'h00;
    else if (integrating && contStrobe && !prevCs)
      csCount <= csCount + 8'h01;
  end
  assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & gpioExt);
endmodule // strobe_lamp_partner

// [trigger_strobe_timing_tb_top.sv]
`timescale 1ns/10ps
`include "trigger_strobe_defines.vh"

module trigger_strobe_timing_tb_top;
  // ----------------
  // signals
  // ----------------
  logic        core_clk, nrst, wrStb, rdStb, trigCmd;
  logic [7:0]  addr;
  logic [31:0] wrData, rdData, d;
  logic        external_trigger_input, integrating, singleStrobe, contStrobe, lampDrive;
  logic [3:0]  gpioIn, gpioOut, gpioOe, gpioExt;
  logic [1:0]  epOutQuery, epInReply;
  logic [7:0]  csCount;
  int          fails, checksDone, n, m;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
  row_t rows [18];

  trigger_strobe_timing uut (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .external_trigger_input(external_trigger_input), .integrating(integrating),
    .singleStrobe(singleStrobe), .contStrobe(contStrobe), .lampDrive(lampDrive), .gpioIn(gpioIn),
    .gpioOut(gpioOut), .gpioOe(gpioOe), .epOutQuery(epOutQuery), .epInReply(epInReply));
  strobe_lamp_partner far (.core_clk(core_clk), .trigCmd(trigCmd), .external_trigger_input(external_trigger_input),
    .integrating(integrating), .contStrobe(contStrobe), .csCount(csCount), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .gpioExt(gpioExt), .gpioIn(gpioIn));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ----------------
  // tasks
  // ----------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic window(input int v, input int lo, input int hi);
    check(32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    wrStb <= 1'b1;
    addr <= a;
    wrData <= v;
    @(posedge core_clk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    rdStb <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rdStb <= 1'b0;
    #1 v = rdData;
  endtask
  // which: 0 integrating, 1 single strobe, 2 continuous strobe
  task automatic waitFor(input int which, input logic lvl, input int lim, input bit must, output int cnt);
    logic s;
    for (cnt = 0; cnt < lim; cnt++) begin
      @(posedge core_clk);
      #1 s = (which == 0) ? integrating : (which == 1) ? singleStrobe : contStrobe;
      if (s === lvl) break;
    end
    if (must && cnt == lim) begin
      fails++;
      $display("CHECK FAILED at %0t: wait ran out, seen %h expected %h", $time, cnt, lim);
      tally_and_finish();
    end
  endtask
  // a fresh reset per acquisition: the 13.3 ms cycle would not fit the run
  task automatic do_reset;
    @(posedge core_clk);
    trigCmd <= 1'b0;
    nrst <= 1'b0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 check(32'({integrating, singleStrobe, contStrobe, lampDrive, gpioOe, epInReply}), 32'h0);
  endtask
  // ----------------
  // sequence
  // ----------------
  initial begin
    {nrst, wrStb, rdStb, trigCmd, addr, wrData, epOutQuery} = '0;
    gpioExt = 4'ha;
    fails = 0;
    checksDone = 0;
    rows = '{'{1'b0, `ADDR_CTRL, 32'h0, 32'h0}, '{1'b0, `ADDR_TRIG_DELAY, 32'h0, 32'h0},
      '{1'b0, `ADDR_SS_DELAY, 32'h0, 32'h5}, '{1'b0, `ADDR_SS_WIDTH, 32'h0, 32'ha},
      '{1'b0, `ADDR_CS_PERIOD, 32'h0, 32'h3e8}, '{1'b0, `ADDR_INTEG_TIME, 32'h0, 32'ha},
      '{1'b0, 8'h2c, 32'h0, 32'h0}, '{1'b1, `ADDR_CTRL, 32'h1, 32'h1}, '{1'b1, `ADDR_CTRL, 32'h3, 32'h1},
      '{1'b1, `ADDR_CTRL, 32'h16, 32'h16}, '{1'b1, `ADDR_CS_PERIOD, 32'ha, 32'h32},
      '{1'b1, `ADDR_CS_PERIOD, 32'h4c4b41, 32'h4c4b40}, '{1'b1, `ADDR_SS_DELAY, 32'h1, 32'h5},
      '{1'b1, `ADDR_SS_DELAY, 32'h100000, 32'h51e8c}, '{1'b1, `ADDR_TRIG_DELAY, 32'h51e8c, 32'h51e8c},
      '{1'b1, 8'h2c, 32'hff, 32'h0}, '{1'b1, `ADDR_GPIO_DIR, 32'hf, 32'hf}, '{1'b1, `ADDR_GPIO_OUT, 32'h5, 32'h5}};
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].wr)
        wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      check(d, rows[i].e);
    end
    check(32'({gpioOe, gpioOut}), 32'hf5);
    repeat (4) @(posedge core_clk);
    rd(`ADDR_GPIO_IN, d);
    check(d, 32'h5);
    wr(`ADDR_GPIO_DIR, 32'h3);
    repeat (4) @(posedge core_clk);
    rd(`ADDR_GPIO_IN, d);
    check(d, 32'h9);
    @(posedge core_clk) epOutQuery <= 2'b01;
    @(posedge core_clk) epOutQuery <= 2'b10;
    #1 check(32'(epInReply), 32'h1);
    @(posedge core_clk) epOutQuery <= 2'b00;
    #1 check(32'(epInReply), 32'h2);
    $display("registers, pins and endpoints done");
    do_reset();
    wr(`ADDR_CTRL, 32'h14);
    check(32'(lampDrive), 32'h0);
    wr(`ADDR_CMD, 32'h1);
    waitFor(0, 1'b1, 10, 1, n);
    check(32'(n), 32'h0);
    check(32'(lampDrive), 32'h1);
    waitFor(1, 1'b1, 700, 1, n);
    window(n + 1, 498, 504);
    waitFor(0, 1'b0, 700, 1, m);
    window(n + m + 2, 998, 1004);
    waitFor(1, 1'b0, 700, 1, n);
    window(n + m + 2, 998, 1004);
    rd(`ADDR_STATUS, d);
    check(d & 32'h3, 32'h2);
    wr(`ADDR_CMD, 32'h1);
    waitFor(0, 1'b1, 2000, 0, n);
    check(32'(n), 32'd2000);
    $display("normal mode done");
    do_reset();
    trigCmd <= 1'b1;
    wr(`ADDR_CTRL, 32'h11);
    wr(`ADDR_CMD, 32'h1);
    trigCmd <= 1'b0;
    waitFor(0, 1'b1, 100, 0, n);
    check(32'(n), 32'd100);
    trigCmd <= 1'b1;
    waitFor(0, 1'b1, 100, 1, n);
    window(n + 1, 10, 30);
    $display("external trigger done");
    do_reset();
    wr(`ADDR_TRIG_DELAY, 32'h5);
    wr(`ADDR_SS_DELAY, 32'ha);
    wr(`ADDR_CTRL, 32'h11);
    wr(`ADDR_CMD, 32'h1);
    trigCmd <= 1'b1;
    waitFor(0, 1'b1, 700, 1, n);
    window(n + 1, 505, 535);
    waitFor(1, 1'b1, 700, 1, m);
    window(n + m + 2, 1005, 1035);
    $display("delayed trigger done");
    do_reset();
    wr(`ADDR_CS_PERIOD, 32'h32);
    wr(`ADDR_INTEG_TIME, 32'h64);
    wr(`ADDR_CTRL, 32'h0a);
    wr(`ADDR_CMD, 32'h1);
    waitFor(0, 1'b1, 12000, 1, n);
    waitFor(2, 1'b1, 600, 1, n);
    window(n + 1, 420, 428);
    waitFor(0, 1'b0, 11000, 1, n);
    check(32'(csCount), 32'h2);
    waitFor(2, 1'b1, 6000, 1, n);
    waitFor(2, 1'b0, 200, 1, n);
    waitFor(2, 1'b1, 6000, 1, m);
    window(n + m + 2, 4999, 5003);
    $display("internal trigger done");
    tally_and_finish();
  end
endmodule // trigger_strobe_timing_tb_top
